// >>> hdl/spi_audio_error_config.sv
// Serial audio unit: APB registers, sampled-clock slave link, error events and interrupt.
`timescale 1ns/1ps
module spi_audio_error_config
    import spi_audio_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int SLOT = 32,
    parameter int RX_DEPTH = 4
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic SCK_I,
    input wire logic FS_I,
    input wire logic SDI_I,
    output logic SDO_O,
    output logic IRQ_O
);
    localparam int PW = 6;
    localparam int AW = $clog2(RX_DEPTH);
    localparam logic [PW-1:0] W_P = PW'(WIDTH);
    localparam logic [PW-1:0] LAST_P = PW'(WIDTH - 1);
    localparam logic [PW-1:0] RJ_OFF = PW'(SLOT - WIDTH);
    localparam logic [PW-1:0] POS_MAX = 6'h3F;
    localparam logic [AW:0] DEPTH_P = (AW + 1)'(RX_DEPTH);

    // Synchronisers and previous samples
    logic [1:0] sck_s_q;
    logic [1:0] fs_s_q;
    logic [1:0] sdi_s_q;
    logic sck_l_q;
    logic fs_l_q;

    logic on_q;
    logic [31:0] ctrl2_q;
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic halted_q;

    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    logic [PW-1:0] pos_q;
    logic ws_last_q;
    logic [PW-1:0] rx_cnt_q;
    logic [WIDTH-1:0] rx_sh_q;
    logic [WIDTH-1:0] tx_buf_q;
    logic tx_full_q;
    logic [WIDTH-1:0] tx_sh_q;
    logic [WIDTH-1:0] last_word_q;
    logic sdo_q;
    logic irq_q;

    logic [WIDTH-1:0] rx_mem [RX_DEPTH];
    logic [AW:0] rx_wp_q;
    logic [AW:0] rx_rp_q;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sck_s_q <= 2'h0;
            fs_s_q <= 2'h3;
            sdi_s_q <= 2'h0;
            sck_l_q <= 1'b0;
            fs_l_q <= 1'b1;
        end else begin
            sck_s_q <= {sck_s_q[0], SCK_I};
            fs_s_q <= {fs_s_q[0], FS_I};
            sdi_s_q <= {sdi_s_q[0], SDI_I};
            sck_l_q <= sck_s_q[1];
            fs_l_q <= fs_s_q[1];
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic fs_now;
    logic sdi_now;
    assign sck_rise = sck_s_q[1] & ~sck_l_q;
    assign sck_fall = ~sck_s_q[1] & sck_l_q;
    assign fs_now = fs_s_q[1];
    assign sdi_now = sdi_s_q[1];

    // Effective mode
    logic aud_en;
    logic mono;
    audio_fmt_t fmt;
    logic run;
    logic active;
    logic [PW-1:0] off;
    assign aud_en = ctrl2_q[AUDIO_EN_BIT];
    assign mono = aud_en & ctrl2_q[MONO_BIT];
    assign fmt = aud_en ? audio_fmt_t'(ctrl2_q[FMT_LSB +: 2]) : FMT_LEFT;
    assign run = on_q & ~halted_q;
    assign active = aud_en | ~fs_now;

    always_comb begin
        case (fmt)
            FMT_I2S: off = 6'h01;
            FMT_LEFT: off = 6'h00;
            FMT_RIGHT: off = RJ_OFF;
            FMT_PCM: off = 6'h01;
            default: off = 6'h00;
        endcase
    end

    // Slot boundary: channel change, PCM sync pulse, or select fall
    function automatic logic frame_edge(input logic ws, input logic last);
        frame_edge = aud_en ? ((fmt == FMT_PCM) ? (ws & ~last) : (ws ^ last)) : (~ws & last);
    endfunction

    function automatic logic start_at(input logic [PW-1:0] p);
        start_at = aud_en ? ((p == off) || ((fmt == FMT_PCM) && (p == off + W_P))) : (p == 6'h00);
    endfunction

    function automatic logic [PW-1:0] pos_inc(input logic [PW-1:0] p);
        pos_inc = (!aud_en && p == LAST_P) ? 6'h00 : ((p == POS_MAX) ? p : p + 6'h01);
    endfunction

    logic edge_r;
    logic [PW-1:0] pos_n;
    assign edge_r = frame_edge(fs_now, ws_last_q);
    assign pos_n = edge_r ? 6'h00 : pos_inc(pos_q);

    // Receive events
    logic rx_start;
    logic rx_busy;
    logic rx_done;
    logic [WIDTH-1:0] rx_word;
    logic rx_full;
    logic rx_empty;
    logic frm_evt;
    logic ovf_evt;
    assign rx_busy = rx_cnt_q != 6'h00;
    assign rx_start = run & active & sck_rise & start_at(pos_n);
    assign rx_done = run & active & sck_rise & (rx_cnt_q == LAST_P);
    assign rx_word = {rx_sh_q[WIDTH-2:0], sdi_now};
    assign rx_full = (rx_wp_q - rx_rp_q) == DEPTH_P;
    assign rx_empty = rx_wp_q == rx_rp_q;
    assign frm_evt = run & rx_busy & (rx_cnt_q != LAST_P)
        & ((sck_rise & active & (edge_r | rx_start)) | (~aud_en & fs_now & ~fs_l_q));
    assign ovf_evt = rx_done & rx_full;

    // Transmit events
    logic tx_load;
    logic tx_right;
    logic tx_repeat;
    logic undr_evt;
    assign tx_load = run & active & ((sck_fall & start_at(pos_n)) | (~aud_en & ~fs_now & fs_l_q));
    assign tx_right = aud_en & ((fmt == FMT_PCM) ? (pos_n >= off + W_P) : fs_now);
    assign tx_repeat = mono & tx_right;
    assign undr_evt = tx_load & ~tx_repeat & ~tx_full_q;

    // APB decode
    logic acc;
    logic done;
    logic wr;
    logic rd;
    logic mapped;
    logic [WIDTH-1:0] rx_head;
    logic [31:0] rx_rdata;
    logic [31:0] rdata;
    assign acc = PSEL_I & PENABLE_I;
    assign done = acc & pready_q;
    assign wr = done & PWRITE_I & ~pslverr_q;
    assign rd = done & ~PWRITE_I & ~pslverr_q;
    assign mapped = (PADDR_I == CTRL1_OFS) || (PADDR_I == CTRL2_OFS) || (PADDR_I == TXDATA_OFS)
        || (PADDR_I == RXDATA_OFS) || (PADDR_I == STATUS_OFS) || (PADDR_I == MASK_OFS);
    assign rx_head = rx_mem[rx_rp_q[AW-1:0]];

    assign rx_rdata = rx_empty ? 32'h0000_0000
        : {{(32 - WIDTH){ctrl2_q[SGNEXT_BIT] & rx_head[WIDTH-1]}}, rx_head};

    always_comb begin
        rdata = 32'h0000_0000;
        case (PADDR_I)
            CTRL1_OFS: rdata[MODULE_ON_BIT] = on_q;
            CTRL2_OFS: rdata = ctrl2_q & CTRL2_WMASK;
            RXDATA_OFS: rdata = rx_rdata;
            STATUS_OFS: begin
                rdata[2:0] = status_q;
                rdata[ST_HALT_BIT] = halted_q;
                rdata[ST_TXFULL_BIT] = tx_full_q;
                rdata[ST_RXEMPTY_BIT] = rx_empty;
            end
            MASK_OFS: rdata[2:0] = mask_q;
            default: rdata = 32'h0000_0000;
        endcase
    end

    // Answer in the second access cycle
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= acc & ~pready_q;
            if (acc & ~pready_q) begin
                pslverr_q <= ~mapped;
                prdata_q <= (mapped && !PWRITE_I) ? rdata : 32'h0000_0000;
            end else if (done) begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // Control registers
    logic [31:0] c2_wmask;
    assign c2_wmask = on_q ? (CTRL2_WMASK & ~CTRL2_LOCKED) : CTRL2_WMASK;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            on_q <= CTRL1_RESET;
            ctrl2_q <= CTRL2_RESET;
            mask_q <= MASK_RESET;
        end else if (wr) begin
            if (PADDR_I == CTRL1_OFS) begin
                on_q <= PWDATA_I[MODULE_ON_BIT];
            end
            if (PADDR_I == CTRL2_OFS) begin
                ctrl2_q <= (ctrl2_q & ~c2_wmask) | (PWDATA_I & c2_wmask);
            end
            if (PADDR_I == MASK_OFS) begin
                mask_q <= PWDATA_I[2:0];
            end
        end
    end

    // Condition flags: set wins over write-one-to-clear
    logic [2:0] evt;
    logic [2:0] st_clr;
    assign evt = {undr_evt, ovf_evt, frm_evt};
    assign st_clr = (wr && PADDR_I == STATUS_OFS) ? PWDATA_I[2:0] : 3'h0;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= (status_q & ~st_clr) | evt;
        end
    end

    // Critical errors stop the link until the module is switched off
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            halted_q <= 1'b0;
        end else if (!on_q) begin
            halted_q <= 1'b0;
        end else if (ovf_evt && !ctrl2_q[IGNORE_OVF_BIT]) begin
            halted_q <= 1'b1;
        end else if (undr_evt && !ctrl2_q[IGNORE_UNDR_BIT]) begin
            halted_q <= 1'b1;
        end
    end

    // Slot position and receive shifter
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pos_q <= 6'h00;
            ws_last_q <= 1'b1;
            rx_cnt_q <= 6'h00;
            rx_sh_q <= '0;
        end else if (!run || !active) begin
            pos_q <= 6'h00;
            ws_last_q <= fs_now;
            rx_cnt_q <= 6'h00;
        end else if (sck_rise) begin
            pos_q <= pos_n;
            ws_last_q <= fs_now;
            if (rx_start) begin
                rx_cnt_q <= (WIDTH == 1) ? 6'h00 : 6'h01;
                rx_sh_q <= {rx_sh_q[WIDTH-2:0], sdi_now};
            end else if (rx_busy) begin
                rx_cnt_q <= (rx_cnt_q == LAST_P) ? 6'h00 : rx_cnt_q + 6'h01;
                rx_sh_q <= rx_word;
            end
        end
    end

    // Receive FIFO
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
        end else begin
            if (rx_done && !rx_full) begin
                rx_wp_q <= rx_wp_q + (AW + 1)'(1);
            end
            if (rd && PADDR_I == RXDATA_OFS && !rx_empty) begin
                rx_rp_q <= rx_rp_q + (AW + 1)'(1);
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (rx_done && !rx_full) begin
            rx_mem[rx_wp_q[AW-1:0]] <= rx_word;
        end
    end

    // Transmit buffer and shifter
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tx_buf_q <= '0;
            tx_full_q <= 1'b0;
            tx_sh_q <= '0;
            last_word_q <= '0;
            sdo_q <= 1'b0;
        end else begin
            if (tx_load) begin
                if (tx_repeat) begin
                    tx_sh_q <= last_word_q;
                    sdo_q <= last_word_q[WIDTH-1];
                end else if (tx_full_q) begin
                    tx_sh_q <= tx_buf_q;
                    last_word_q <= tx_buf_q;
                    sdo_q <= tx_buf_q[WIDTH-1];
                end else begin
                    tx_sh_q <= '0;
                    last_word_q <= '0;
                    sdo_q <= 1'b0;
                end
            end else if (run && active && sck_fall) begin
                tx_sh_q <= {tx_sh_q[WIDTH-2:0], 1'b0};
                sdo_q <= tx_sh_q[WIDTH-2];
            end else if (!run) begin
                sdo_q <= 1'b0;
            end
            if (wr && PADDR_I == TXDATA_OFS && (!tx_full_q || (tx_load && !tx_repeat))) begin
                tx_buf_q <= PWDATA_I[WIDTH-1:0];
                tx_full_q <= 1'b1;
            end else if (tx_load && !tx_repeat) begin
                tx_full_q <= 1'b0;
            end
        end
    end

    // Error indication
    logic [2:0] evt_en;
    assign evt_en = {ctrl2_q[TX_UNDR_EN_BIT], ctrl2_q[RX_OVF_EN_BIT], ctrl2_q[FRAME_ERR_EN_BIT]};

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q & evt_en);
        end
    end

    assign PRDATA_O = prdata_q;
    assign PREADY_O = pready_q;
    assign PSLVERR_O = pslverr_q;
    assign SDO_O = sdo_q;
    assign IRQ_O = irq_q;

endmodule

// >>> hdl/spi_audio_pkg.sv
// Constants, field layout and types of the serial audio unit with its second control register.
// Function
// - rx_sign_extend set sign-extends words read from FIFO
// - frame_err_event_en gates frame errors onto error events
// - rx_overflow_event_en gates receive overflow onto events
// - tx_underrun_event_en gates transmit underrun onto events
// - ignore_rx_overflow keeps running, FIFO never overwritten
// - Otherwise receive overflow halts serial operation
// - ignore_tx_underrun sends zeros until buffer refills
// - Otherwise transmit underrun halts serial operation
// - audio_protocol_en selects audio codec framing
// - audio_mono repeats each word on both channels
// - Audio fields writable only while module disabled
// - Mono and format matter only with audio enabled
// - Bits 31 to 16 read zero, ignore writes
package spi_audio_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL1_OFS = 8'h00;
    localparam logic [7:0] CTRL2_OFS = 8'h04;
    localparam logic [7:0] TXDATA_OFS = 8'h08;
    localparam logic [7:0] RXDATA_OFS = 8'h0C;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] MASK_OFS = 8'h14;

    // First control register
    localparam int MODULE_ON_BIT = 15;

    // serial_control_two fields
    localparam int SGNEXT_BIT = 15;
    localparam int FRAME_ERR_EN_BIT = 12;
    localparam int RX_OVF_EN_BIT = 11;
    localparam int TX_UNDR_EN_BIT = 10;
    localparam int IGNORE_OVF_BIT = 9;
    localparam int IGNORE_UNDR_BIT = 8;
    localparam int AUDIO_EN_BIT = 7;
    localparam int MONO_BIT = 3;
    localparam int FMT_LSB = 0;
    localparam logic [31:0] CTRL2_WMASK = 32'h0000_9F8B;
    localparam logic [31:0] CTRL2_LOCKED = 32'h0000_008B;

    // Status and mask layout
    localparam int ST_FRM_BIT = 0;
    localparam int ST_OVF_BIT = 1;
    localparam int ST_UNDR_BIT = 2;
    localparam int ST_HALT_BIT = 8;
    localparam int ST_TXFULL_BIT = 9;
    localparam int ST_RXEMPTY_BIT = 10;

    // Reset values
    localparam logic CTRL1_RESET = 1'b0;
    localparam logic [31:0] CTRL2_RESET = 32'h0000_0000;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;

    typedef enum logic [1:0] {
        FMT_I2S = 2'b00,
        FMT_LEFT = 2'b01,
        FMT_RIGHT = 2'b10,
        FMT_PCM = 2'b11
    } audio_fmt_t;

endpackage

// >>> bench/spi_audio_error_config_properties.sv
// Port-level checker of the serial audio unit, with its bind.
`timescale 1ns/1ps
module spi_audio_checker
    import spi_audio_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic IRQ_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic on_q;
    logic [31:0] lock_q;
    logic [31:0] free_q;
    logic [2:0] mask_q;
    logic [2:0] en_q;
    logic done;
    logic rd2;
    assign done = PREADY_O && PWRITE_I && !PSLVERR_O;
    assign rd2 = PREADY_O && !PWRITE_I && PADDR_I == CTRL2_OFS;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            on_q <= 1'b0;
            mask_q <= 3'h0;
        end else if (done && PADDR_I == CTRL1_OFS) begin
            on_q <= PWDATA_I[MODULE_ON_BIT];
        end else if (done && PADDR_I == MASK_OFS) begin
            mask_q <= PWDATA_I[2:0];
        end
    end
    // Shadow of serial_control_two, locked part follows the module enable
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            lock_q <= 32'h0000_0000;
            free_q <= 32'h0000_0000;
            en_q <= 3'h0;
        end else if (done && PADDR_I == CTRL2_OFS) begin
            free_q <= PWDATA_I & CTRL2_WMASK & ~CTRL2_LOCKED;
            en_q <= {PWDATA_I[TX_UNDR_EN_BIT], PWDATA_I[RX_OVF_EN_BIT], PWDATA_I[FRAME_ERR_EN_BIT]};
            if (!on_q) begin
                lock_q <= PWDATA_I & CTRL2_LOCKED;
            end
        end
    end
    sequence setup_s;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence access_s;
        PSEL_I && PENABLE_I;
    endsequence
    AST_READY_LATENCY: assert property (setup_s ##1 access_s |=> PREADY_O)
        else $error("ready late after first access cycle");
    AST_READY_ONE: assert property (PREADY_O |=> !PREADY_O)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (PSLVERR_O |-> PREADY_O)
        else $error("error without ready");
    AST_ERR_UNMAPPED: assert property (PREADY_O |-> PSLVERR_O == (PADDR_I > MASK_OFS || PADDR_I[1:0] != 2'b00))
        else $error("error flag does not match address");
    AST_CTRL2_UPPER: assert property (rd2 |-> PRDATA_O[31:16] == 16'h0000)
        else $error("upper control bits not zero");
    AST_CTRL2_LOCK: assert property (rd2 |-> (PRDATA_O & CTRL2_LOCKED) == lock_q)
        else $error("audio fields changed while enabled");
    AST_CTRL2_FREE: assert property (rd2 |-> (PRDATA_O & ~CTRL2_LOCKED) == free_q)
        else $error("control readback wrong");
    AST_IRQ_GATED: assert property (IRQ_O |-> ($past(mask_q) & $past(en_q)) != 3'h0)
        else $error("interrupt without enabled event");
endmodule

bind spi_audio_error_config spi_audio_checker chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O)
);

// >>> bench/spi_audio_partner.sv
// Serial master model: drives bit clock, select and data, captures returned bits.
`timescale 1ns/1ps
module spi_audio_partner (
    output logic sck_o,
    output logic fs_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    logic [15:0] got = 16'h0000;
    logic [15:0] got_r = 16'h0000;
    initial begin
        sck_o = 1'b0;
        fs_o = 1'b1;
        sdi_o = 1'b0;
    end
    // Clock stands low outside frames; data flips when released
    task automatic xfer(input logic [15:0] w, input int n);
        #7;
        fs_o = 1'b0;
        #400;
        for (int i = 15; i > 15 - n; i--) begin
            sdi_o = w[i];
            #200;
            got[i] = sdo_i;
            sck_o = 1'b1;
            #200;
            sck_o = 1'b0;
        end
        #400;
        fs_o = 1'b1;
        sdi_o = ~sdi_o;
        #400;
    endtask
    // Left-justified frame: select flips with the falling clock, 32-bit slots
    task automatic frame(input logic [15:0] l, input logic [15:0] r);
        sck_o = 1'b1;
        #200;
        for (int i = 63; i >= 0; i--) begin
            sck_o = 1'b0;
            fs_o = (i < 32);
            sdi_o = (i % 32 > 15) && ((i < 32) ? r[i % 16] : l[i % 16]);
            #200;
            if (i > 47) begin
                got[i % 16] = sdo_i;
            end else if (i % 32 > 15) begin
                got_r[i % 16] = sdo_i;
            end
            sck_o = 1'b1;
            #200;
        end
        sck_o = 1'b0;
    endtask
endmodule

// >>> bench/spi_audio_error_config_tb.sv
// Bench for the serial audio unit: registers, link words, error events.
`timescale 1ns/1ps
module spi_audio_error_config_tb
    import spi_audio_pkg::*;
;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdata;
    logic pready, pslverr, serr, sck, fs, sdi, sdo, irq;
    int failures = 0;
    int total_checks = 0;
    row_t rows [8] = '{
        '{CTRL2_OFS, 32'hFFFF_FFFF, 32'h0000_9F8B},
        '{CTRL2_OFS, 32'h0000_0083, 32'h0000_0083},
        '{CTRL2_OFS, 32'h0000_0082, 32'h0000_0082},
        '{CTRL2_OFS, 32'h0000_0081, 32'h0000_0081},
        '{CTRL2_OFS, 32'h0000_0080, 32'h0000_0080},
        '{CTRL2_OFS, 32'h0000_0008, 32'h0000_0008},
        '{MASK_OFS, 32'hFFFF_FFFF, 32'h0000_0007},
        '{TXDATA_OFS, 32'h0000_1234, 32'h0000_0000}
    };
    spi_audio_error_config #(.RX_DEPTH(2)) dut (
        .CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .SCK_I(sck), .FS_I(fs), .SDI_I(sdi), .SDO_O(sdo), .IRQ_O(irq)
    );
    spi_audio_partner mdl (.sck_o(sck), .fs_o(fs), .sdi_o(sdi), .sdo_i(sdo));
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic wrap_up;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            wrap_up();
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check($sformatf("read %h", a), rdata & m, e);
    endtask
    task automatic irqc(input logic e);
        repeat (3) @(posedge clk);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d);
            rdc(rows[i].a, 32'hFFFF_FFFF, rows[i].e);
        end
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rdc(CTRL2_OFS, 32'hFFFF_FFFF, 32'h0);
        rdc(MASK_OFS, 32'hFFFF_FFFF, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped", {31'h0, serr}, 32'h1);
        apb(1'b1, CTRL1_OFS, 32'h0000_8000);
        apb(1'b1, CTRL2_OFS, 32'h0000_9F8B);
        rdc(CTRL2_OFS, 32'hFFFF_FFFF, 32'h0000_9F00);
        apb(1'b1, CTRL2_OFS, 32'h0000_0300);
        apb(1'b1, TXDATA_OFS, 32'h0000_A5C3);
        mdl.xfer(16'h8123, 16);
        check("sdo", {16'h0, mdl.got}, 32'h0000_A5C3);
        rdc(RXDATA_OFS, 32'hFFFF_FFFF, 32'h0000_8123);
        apb(1'b1, CTRL2_OFS, 32'h0000_8700);
        apb(1'b1, MASK_OFS, 32'h7);
        mdl.xfer(16'h8001, 16);
        check("sdo", {16'h0, mdl.got}, 32'h0);
        rdc(RXDATA_OFS, 32'hFFFF_FFFF, 32'hFFFF_8001);
        rdc(STATUS_OFS, 32'h0000_0106, 32'h0000_0004);
        irqc(1'b1);
        apb(1'b1, CTRL2_OFS, 32'h0000_8300);
        irqc(1'b0);
        apb(1'b1, STATUS_OFS, 32'h7);
        for (int i = 1; i < 4; i++) begin
            mdl.xfer(16'(i), 16);
        end
        rdc(STATUS_OFS, 32'h0000_0102, 32'h0000_0002);
        irqc(1'b0);
        rdc(RXDATA_OFS, 32'hFFFF_FFFF, 32'h1);
        rdc(RXDATA_OFS, 32'hFFFF_FFFF, 32'h2);
        apb(1'b1, CTRL2_OFS, 32'h0000_0900);
        apb(1'b1, STATUS_OFS, 32'h7);
        for (int i = 4; i < 7; i++) begin
            mdl.xfer(16'(i), 16);
        end
        rdc(STATUS_OFS, 32'h0000_0102, 32'h0000_0102);
        irqc(1'b1);
        apb(1'b1, CTRL1_OFS, 32'h0);
        apb(1'b1, CTRL2_OFS, 32'h0000_1000);
        apb(1'b1, CTRL1_OFS, 32'h0000_8000);
        apb(1'b0, RXDATA_OFS, 32'h0);
        apb(1'b0, RXDATA_OFS, 32'h0);
        apb(1'b1, STATUS_OFS, 32'h7);
        apb(1'b1, TXDATA_OFS, 32'h0000_1234);
        mdl.xfer(16'h00FF, 8);
        rdc(STATUS_OFS, 32'h0000_0101, 32'h0000_0001);
        irqc(1'b1);
        mdl.xfer(16'h0F0F, 16);
        rdc(STATUS_OFS, 32'h0000_0104, 32'h0000_0104);
        apb(1'b1, CTRL1_OFS, 32'h0);
        apb(1'b1, CTRL2_OFS, 32'h0000_0189);
        apb(1'b1, STATUS_OFS, 32'h7);
        apb(1'b1, TXDATA_OFS, 32'h0000_5A3C);
        apb(1'b1, CTRL1_OFS, 32'h0000_8000);
        mdl.frame(16'h1357, 16'h2468);
        check("left", {16'h0, mdl.got}, 32'h0000_5A3C);
        check("right", {16'h0, mdl.got_r}, 32'h0000_5A3C);
        rdc(RXDATA_OFS, 32'hFFFF_FFFF, 32'h0000_1357);
        rdc(RXDATA_OFS, 32'hFFFF_FFFF, 32'h0000_2468);
        rdc(STATUS_OFS, 32'h0000_0107, 32'h0000_0000);
        wrap_up();
    end
endmodule
